// >>> hw/reset_timeout_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module reset_timeout_sequencer
  import reset_seq_pkg::*;
#(
  parameter int POWER_UP_TIMER_CYC = POWER_UP_DELAY_CYC,
  parameter int BOR_CYC = BROWN_OUT_MIN_CYC,
  parameter int OST_CYC = OSC_STARTUP_CYCLES,
  parameter int FILT_CYC = MASTER_CLEAR_N_FILTER_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // pins and supply detectors
  input wire logic master_clear_n,
  input wire logic supply_rise,
  input wire logic supply_low,
  input wire logic rc_osc_tick,
  input wire logic oscillator_input,
  // configuration
  input wire logic power_up_timer_cfg,
  input wire logic brown_out_enable_cfg,
  input wire logic [1:0] osc_mode_cfg,
  // internal reset sources
  input wire logic watchdog_timer_reset,
  input wire logic sleep_wakeup,
  // results
  output logic core_reset,
  output logic por_flag,
  output logic bor_flag,
  output logic timeout_busy
);
  // counter widths hold the full limit, so a compare never sees a wrap
  localparam int PW = $clog2(POWER_UP_TIMER_CYC + 1);
  localparam int BW = $clog2(BOR_CYC + 1);
  localparam int OW = $clog2(OST_CYC + 1);

  // pin and detector levels after synchronisation
  logic master_clear_n_ok;
  logic rise_s;
  logic low_s;
  logic rc_s;
  logic osc_s;

  // the pin idles high; starting low keeps the core held until it has settled
  sync_filter #(
    .FILT_CYC(FILT_CYC),
    .INIT(1'b0)
  ) u_master_clear_n (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din(master_clear_n),
    .dout(master_clear_n_ok)
  );
  sync_filter #(
    .FILT_CYC(1),
    .INIT(1'b0)
  ) u_rise (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din(supply_rise),
    .dout(rise_s)
  );
  // a low supply is assumed until the detector has been sampled
  sync_filter #(
    .FILT_CYC(1),
    .INIT(1'b1)
  ) u_low (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din(supply_low),
    .dout(low_s)
  );
  // the oscillators only need a clean edge, so no filtering beyond one flop
  sync_filter #(
    .FILT_CYC(1),
    .INIT(1'b0)
  ) u_rc (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din(rc_osc_tick),
    .dout(rc_s)
  );
  sync_filter #(
    .FILT_CYC(1),
    .INIT(1'b0)
  ) u_osc (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din(oscillator_input),
    .dout(osc_s)
  );

  // last count of each timer, sized to its counter
  localparam logic [PW-1:0] POWER_UP_TIMER_LAST = PW'(POWER_UP_TIMER_CYC);
  localparam logic [BW-1:0] BOR_LAST = BW'(BOR_CYC - 1);
  localparam logic [OW-1:0] OST_LAST = OW'(OST_CYC);

  // low-power, crystal and high-speed modes need the start-up count; RC does not
  function automatic logic crystal_mode(input logic [1:0] m);
    logic hit;
    hit = 1'b0;
    case (m)
      OSC_MODE_LP: hit = 1'b1;
      OSC_MODE_XT: hit = 1'b1;
      OSC_MODE_HS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // where to go once the power-up delay is over or skipped
  function automatic seq_state_t after_delay(input logic need_ost, input logic power_on_path);
    seq_state_t s;
    if (need_ost && power_on_path) begin
      s = ST_OST;
    end else begin
      s = ST_RUN;
    end
    return s;
  endfunction

  // every state but run keeps the core in reset
  function automatic logic holds_reset(input seq_state_t s);
    logic hold;
    hold = 1'b1;
    if (s == ST_RUN) begin
      hold = 1'b0;
    end
    return hold;
  endfunction

  typedef struct packed {
    // sequencer state and its three timers
    seq_state_t state_ff;
    logic [PW-1:0] power_up_timer_ff;
    logic [BW-1:0] bor_ff;
    logic [OW-1:0] ost_ff;
    // last synchronised levels, for edge detection
    logic rise_d_ff;
    logic rc_d_ff;
    logic osc_d_ff;
    // watchdog request seen on the previous edge
    logic wdt_ff;
    // set by power-on, cleared by brown-out: decides whether the start-up count runs
    logic por_path_ff;
    // registered outputs
    logic core_reset_ff;
    logic por_flag_ff;
    logic bor_flag_ff;
    logic busy_ff;
  } seq_t;

  // both delay timers back to zero
  function automatic seq_t clear_timers(input seq_t s);
    seq_t r;
    r = s;
    r.power_up_timer_ff = '0;
    r.ost_ff = '0;
    return r;
  endfunction

  // one copy holds the state, the other what it becomes at the next edge
  seq_t st_ff;
  seq_t nxt_st;

  logic power_up_timer_en;
  logic rise_edge;
  logic rc_edge;
  logic osc_edge;
  logic bor_low;
  logic bor_trip;
  logic ost_needed;
  logic [2:0] edge_now;
  logic [2:0] edge_last;
  logic [2:0] edge_seen;

  // one rising-edge detector each for the synchronised supply rise, RC tick and oscillator
  assign edge_now = {osc_s, rc_s, rise_s};
  assign edge_last = {st_ff.osc_d_ff, st_ff.rc_d_ff, st_ff.rise_d_ff};
  for (genvar g = 0; g < 3; g++) begin : g_edge
    assign edge_seen[g] = edge_now[g] && !edge_last[g];
  end

  always_comb begin
    // an enabled brown-out detector forces the power-up delay on
    power_up_timer_en = power_up_timer_cfg || brown_out_enable_cfg;
    rise_edge = edge_seen[0];
    rc_edge = edge_seen[1];
    osc_edge = edge_seen[2];
    // a low supply only counts while the detector is enabled
    bor_low = brown_out_enable_cfg && low_s;
    // dips shorter than the minimum duration are forgiven
    bor_trip = bor_low && (st_ff.bor_ff >= BOR_LAST);
    ost_needed = crystal_mode(osc_mode_cfg);
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rise_d_ff = rise_s;
    nxt_st.rc_d_ff = rc_s;
    nxt_st.osc_d_ff = osc_s;
    nxt_st.wdt_ff = watchdog_timer_reset;

    // the duration counter parks one short of the limit while the trip holds
    if (bor_low && !bor_trip) begin
      nxt_st.bor_ff = st_ff.bor_ff + BW'(1);
    end else if (!bor_low) begin
      nxt_st.bor_ff = '0;
    end

    case (st_ff.state_ff)
      ST_POR: begin
        // every power-on starts both timers from zero
        nxt_st = clear_timers(nxt_st);
        if (power_up_timer_en) begin
          nxt_st.state_ff = ST_POWER_UP_TIMER;
        end else begin
          // delay disabled: straight on to the start-up count or to run
          nxt_st.state_ff = after_delay(ost_needed, st_ff.por_path_ff);
        end
      end
      ST_BROWN: begin
        // held here for as long as the supply stays low
        nxt_st = clear_timers(nxt_st);
        if (!bor_low) begin
          nxt_st.state_ff = ST_POWER_UP_TIMER;
        end
      end
      ST_POWER_UP_TIMER: begin
        // one step per synchronised rising edge of the slow RC tick
        if (rc_edge) begin
          nxt_st.power_up_timer_ff = st_ff.power_up_timer_ff + PW'(1);
        end
        if (st_ff.power_up_timer_ff >= POWER_UP_TIMER_LAST) begin
          nxt_st.ost_ff = '0;
          // after a brown-out the oscillator never stopped, so no start-up count
          nxt_st.state_ff = after_delay(ost_needed, st_ff.por_path_ff);
        end
      end
      ST_OST: begin
        // a stopped oscillator holds the core in reset for good
        if (osc_edge) begin
          nxt_st.ost_ff = st_ff.ost_ff + OW'(1);
        end
        if (st_ff.ost_ff >= OST_LAST) begin
          nxt_st.state_ff = ST_RUN;
        end
      end
      ST_RUN: begin
        // a wake-up in a crystal mode reruns the start-up count
        if (sleep_wakeup && ost_needed) begin
          nxt_st.ost_ff = '0;
          nxt_st.state_ff = ST_OST;
        end
      end
      default: begin
        // an illegal code falls back to a fresh power-on
        nxt_st.state_ff = ST_POR;
      end
    endcase

    // brown-out takes over from any state, restarting the power-up timer
    if (bor_trip) begin
      nxt_st = clear_timers(nxt_st);
      nxt_st.state_ff = ST_BROWN;
      nxt_st.bor_flag_ff = 1'b1;
      nxt_st.por_path_ff = 1'b0;
    end
    // power-on wins over a brown-out trip in the same cycle
    if (rise_edge) begin
      nxt_st = clear_timers(nxt_st);
      nxt_st.state_ff = ST_POR;
      nxt_st.por_flag_ff = 1'b1;
      nxt_st.bor_flag_ff = 1'b0;
      nxt_st.por_path_ff = 1'b1;
    end

    nxt_st.busy_ff = holds_reset(nxt_st.state_ff);
    // timers keep running under master-clear; release is immediate if done
    // the watchdog reset is stretched to two edges and never reaches the pin
    nxt_st.core_reset_ff = holds_reset(nxt_st.state_ff) || !master_clear_n_ok ||
                           watchdog_timer_reset || st_ff.wdt_ff;
  end

  // reset looks like a fresh power-on with the core held
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff.state_ff <= ST_POR;
      st_ff.power_up_timer_ff <= '0;
      st_ff.bor_ff <= '0;
      st_ff.ost_ff <= '0;
      st_ff.rise_d_ff <= 1'b0;
      st_ff.rc_d_ff <= 1'b0;
      st_ff.osc_d_ff <= 1'b0;
      st_ff.wdt_ff <= 1'b0;
      st_ff.por_path_ff <= 1'b1;
      st_ff.core_reset_ff <= 1'b1;
      st_ff.por_flag_ff <= 1'b1;
      st_ff.bor_flag_ff <= 1'b0;
      st_ff.busy_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // every output comes straight from a state flop
  assign core_reset = st_ff.core_reset_ff;
  assign por_flag = st_ff.por_flag_ff;
  assign bor_flag = st_ff.bor_flag_ff;
  assign timeout_busy = st_ff.busy_ff;
endmodule
`default_nettype wire

// >>> inc/reset_seq_pkg.sv
package reset_seq_pkg;
  localparam int CLK_HZ = 25000000;
  // power-up delay, nominal figure in milliseconds
  localparam int POWER_UP_DELAY_MS = 72;
  localparam int POWER_UP_DELAY_CYC = (POWER_UP_DELAY_MS * (CLK_HZ / 1000));
  // brown-out minimum duration in microseconds
  localparam int BROWN_OUT_MIN_DURATION_US = 100;
  localparam int BROWN_OUT_MIN_CYC = (BROWN_OUT_MIN_DURATION_US * (CLK_HZ / 1000000));
  localparam int OSC_STARTUP_CYCLES = 1024;
  // master-clear noise filter length in clocks
  localparam int MASTER_CLEAR_N_FILTER_CYC = 8;
  // oscillator mode encoding
  localparam logic [1:0] OSC_MODE_LP = 2'h0;
  localparam logic [1:0] OSC_MODE_XT = 2'h1;
  localparam logic [1:0] OSC_MODE_HS = 2'h2;
  localparam logic [1:0] OSC_MODE_RC = 2'h3;
  typedef enum logic [4:0] {
    ST_POR = 5'h01,
    ST_BROWN = 5'h02,
    ST_POWER_UP_TIMER = 5'h04,
    ST_OST = 5'h08,
    ST_RUN = 5'h10
  } seq_state_t;
endpackage

// >>> hw/sync_filter.sv
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser followed by a stability filter
module sync_filter
  import reset_seq_pkg::*;
#(
  parameter int FILT_CYC = 1,
  parameter logic INIT = 1'b0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // raw and cleaned level
  input wire logic din,
  output logic dout
);
  localparam int CW = $clog2(FILT_CYC + 1);
  typedef struct packed {
    logic s1_ff;
    logic s2_ff;
    logic out_ff;
    logic [CW-1:0] cnt_ff;
  } sf_state_t;
  sf_state_t st_ff;
  sf_state_t nxt_st;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1_ff = din;
    nxt_st.s2_ff = st_ff.s1_ff;
    if (st_ff.s2_ff == st_ff.out_ff) begin
      nxt_st.cnt_ff = '0;
    end else if (st_ff.cnt_ff >= CW'(FILT_CYC - 1)) begin
      nxt_st.out_ff = st_ff.s2_ff;
      nxt_st.cnt_ff = '0;
    end else begin
      nxt_st.cnt_ff = st_ff.cnt_ff + CW'(1);
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff <= '{s1_ff: INIT, s2_ff: INIT, out_ff: INIT, cnt_ff: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign dout = st_ff.out_ff;
endmodule
`default_nettype wire

// >>> tb/reset_seq_props.sv
`timescale 1ns/1ns
`default_nettype none
module reset_seq_props #(
  parameter int FILT_CYC = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // watched inputs
  input wire logic master_clear_n,
  input wire logic supply_rise,
  input wire logic brown_out_enable_cfg,
  input wire logic watchdog_timer_reset,
  // watched outputs
  input wire logic core_reset,
  input wire logic bor_flag,
  input wire logic por_flag,
  input wire logic timeout_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [7:0] low_ff;
  always_ff @(posedge clk_sys) begin
    low_ff <= master_clear_n ? 8'h00 : low_ff + {7'h00, low_ff != 8'hff};
  end
  sequence s_rise; $rose(supply_rise); endsequence
  sequence s_trip; $rose(bor_flag); endsequence
  property p_init; $rose(rst_n) |-> core_reset && timeout_busy && por_flag && !bor_flag; endproperty
  property p_busy; timeout_busy |-> core_reset; endproperty
  property p_wdt; watchdog_timer_reset |=> core_reset; endproperty
  property p_master_clear_n; low_ff >= FILT_CYC + 4 |-> core_reset; endproperty
  property p_bor_en; s_trip |-> $past(brown_out_enable_cfg); endproperty
  property p_trip; s_trip |-> ##[0:1] (core_reset && timeout_busy); endproperty
  property p_por; s_rise |-> ##[2:5] (timeout_busy && por_flag); endproperty
  property p_go; $fell(core_reset) |-> $past(master_clear_n, 3) && !timeout_busy; endproperty
  a_init: assert property (p_init) else $error("bad reset values");
  a_busy: assert property (p_busy) else $error("busy without reset");
  a_wdt: assert property (p_wdt) else $error("watchdog ignored");
  a_master_clear_n: assert property (p_master_clear_n) else $error("low pin ignored");
  a_bor_en: assert property (p_bor_en) else $error("trip while disabled");
  a_trip: assert property (p_trip) else $error("trip without reset");
  a_por: assert property (p_por) else $error("rise ignored");
  a_go: assert property (p_go) else $error("early release");
endmodule
`default_nettype wire

// >>> tb/supply_model.sv
`timescale 1ns/1ns
`default_nettype none
module supply_model (
  // bench requests
  input wire logic vdd_on,
  input wire logic vdd_dip,
  input wire logic button_n,
  // detectors, pin and oscillators
  output logic supply_rise,
  output logic supply_low,
  output logic master_clear_n,
  output var logic rc_osc_tick = 1'b0,
  output var logic oscillator_input = 1'b0
);
  // both run free; the RC tick always toggles on a falling clock edge
  always #160 rc_osc_tick = ~rc_osc_tick;
  // a half period of 96 never lands on a rising clock edge
  always #96 oscillator_input = ~oscillator_input;
  assign supply_rise = vdd_on;
  assign supply_low = vdd_dip;
  assign master_clear_n = button_n;
endmodule
`default_nettype wire

// >>> tb/reset_timeout_sequencer_tb.sv
`timescale 1ns/1ns
`default_nettype none
module reset_timeout_sequencer_tb;
  import reset_seq_pkg::*;
  localparam int PW = 4;
  localparam int BO = 4;
  localparam int OS = 4;
  logic clk_sys = 1'b0, rst_n = 1'b0, on = 1'b0, dip = 1'b0, btn_n = 1'b1;
  logic pw_cfg = 1'b0, bo_cfg = 1'b0, wdt = 1'b0, wake = 1'b0;
  logic [1:0] mode = 2'h0;
  logic master_clear_n_n, rise, low, rc, osc, core_reset, por_flag, bor_flag, busy;
  int bad_count = 0;
  int n_compared = 0;
  int t;
  logic [31:0] seed = 32'haa1c;
  always #20 clk_sys = ~clk_sys;
  supply_model supply_model_i (.vdd_on(on), .vdd_dip(dip), .button_n(btn_n),
    .supply_rise(rise), .supply_low(low), .master_clear_n(master_clear_n_n),
    .rc_osc_tick(rc), .oscillator_input(osc));
  reset_timeout_sequencer #(.POWER_UP_TIMER_CYC(PW), .BOR_CYC(BO), .OST_CYC(OS))
    reset_timeout_sequencer_i (.clk_sys(clk_sys), .rst_n(rst_n), .master_clear_n(master_clear_n_n),
    .supply_rise(rise), .supply_low(low), .rc_osc_tick(rc), .oscillator_input(osc),
    .power_up_timer_cfg(pw_cfg), .brown_out_enable_cfg(bo_cfg), .osc_mode_cfg(mode),
    .watchdog_timer_reset(wdt), .sleep_wakeup(wake), .core_reset(core_reset),
    .por_flag(por_flag), .bor_flag(bor_flag), .timeout_busy(busy));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  // each counted edge needs at least one full source period
  function automatic int min_wait(input logic pw, input logic oscillator_startup_timer);
    return (pw ? (PW - 1) * 8 : 0) + (oscillator_startup_timer ? (OS - 1) * 4 : 0);
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic dip_for(input int n);
    dip <= 1'b1;
    cyc(n);
    dip <= 1'b0;
  endtask
  initial begin
    cyc(4);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      on <= 1'b0;
      pw_cfg <= seed[0];
      mode <= 2'(i);
      cyc(6);
      on <= 1'b1;
      wait_for(core_reset, 1'b1, 8, t);
      check(8'(t < 8), 8'h01);
      wait_for(core_reset, 1'b0, 2000, t);
      check(8'(t >= min_wait(seed[0], i % 4 != 3) && t < 2000), 8'h01);
    end
    $display("power-on sequences done");
    btn_n <= 1'b0;
    cyc(MASTER_CLEAR_N_FILTER_CYC - 3);
    btn_n <= 1'b1;
    cyc(MASTER_CLEAR_N_FILTER_CYC + 4);
    check(8'(core_reset), 8'h00);
    btn_n <= 1'b0;
    on <= 1'b0;
    cyc(6);
    on <= 1'b1;
    cyc(300);
    check(8'(core_reset), 8'h01);
    btn_n <= 1'b1;
    wait_for(core_reset, 1'b0, 40, t);
    check(8'(t < MASTER_CLEAR_N_FILTER_CYC + 6), 8'h01);
    wdt <= 1'b1;
    cyc(1);
    wdt <= 1'b0;
    cyc(1);
    check({6'h00, core_reset, master_clear_n_n}, 8'h03);
    wait_for(core_reset, 1'b0, 10, t);
    $display("pin and watchdog done");
    bo_cfg <= 1'b1;
    pw_cfg <= 1'b0;
    cyc(3);
    dip_for(BO - 2);
    cyc(8);
    check({6'h00, bor_flag, core_reset}, 8'h00);
    dip_for(BO + 8);
    check({6'h00, bor_flag, core_reset}, 8'h03);
    cyc(10);
    dip_for(BO + 8);
    wait_for(core_reset, 1'b0, 2000, t);
    check(8'(t >= min_wait(1'b1, 1'b0) && t < 2000), 8'h01);
    bo_cfg <= 1'b0;
    cyc(3);
    dip_for(BO + 8);
    check(8'(core_reset), 8'h00);
    $display("brown-out done");
    mode <= OSC_MODE_XT;
    wake <= 1'b1;
    cyc(1);
    wake <= 1'b0;
    wait_for(busy, 1'b1, 4, t);
    check(8'(t < 4), 8'h01);
    wait_for(busy, 1'b0, 200, t);
    $display("wake-up done");
    close_out();
  end
  initial begin
    cyc(40000);
    bad_count++;
    close_out();
  end
endmodule
bind reset_timeout_sequencer reset_seq_props #(.FILT_CYC(FILT_CYC)) props_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .master_clear_n(master_clear_n),
  .supply_rise(supply_rise), .brown_out_enable_cfg(brown_out_enable_cfg),
  .watchdog_timer_reset(watchdog_timer_reset), .core_reset(core_reset),
  .bor_flag(bor_flag), .por_flag(por_flag), .timeout_busy(timeout_busy));
`default_nettype wire
